// *** core/msc_serial_mode_control.sv ***
// Purpose: serial control port and mode control of a low-speed modem
// Assumes: sck, latch_en, rw_dir, data pin driven by a host processor
// Notes:   sck clocks the shift side; everything else runs on clk
//
// Operation
// - control word is 16 bits: mode, atten/gain, tone, mute, band, detect time.
// - with direction low, data pin shifts into control shift register on sck rise.
// - direction low and trigger high passes word to mode logic; low isolates it.
// - direction high, trigger rise loads received tone code, bit 0 on data pin.
// - each sck rise in a read shows next status bit: 1,2,3,0 and wrapping.
// - mode field decodes 0..9 into the ten documented function modes.
// - rx data high in tone/answer/call_progress_detect modes; detect high in tx-tone modes; pd tri-states.
// - fsk mode modulates and demodulates; detect output low on valid carrier.
// - call-progress mode detects 400 Hz; detect output low while tone present.
// - tone receive disables transmitter; detect low as data valid on tone.
// - tone loopback routes generator into receiver; valid tone drives output low.
// - fsk loopback ties modulator output to demodulator input for self test.
// - answer tone makes 2100 Hz with receiver off; tone tx modes disable receiver.
// - power-down 1 stops all but oscillator; all outputs but oscillator and data pin during reads tri-state.
// - power-down 2 stops everything including oscillator; all outputs but data pin during reads tri-state.
// - in transmit modes the code gives attenuation of 0 to 15 dB.
// - in tone receive the code sets agc gain, clamp at 11, automatic at 12.
// - tone code selects dual pair in tone tx/loopback, single tone in single mode.
// - single tone mode sends exactly one of eight tone frequencies.
// - power-on reset enters power-down 2.
`timescale 1ns/1ps
`default_nettype none

module msc_serial_mode_control
  import msc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ce,
  input  wire logic       sck,
  input  wire logic       latch_en,
  input  wire logic       rw_dir,
  input  wire logic       data_in,
  output logic            data_out,
  output logic            data_oe,
  input  wire logic       fsk_rx_data,
  input  wire logic       fsk_carrier_det_n,
  input  wire logic       call_progress_detect_n,
  input  wire logic       tone_valid_n,
  input  wire logic [3:0] rx_tone_code,
  output logic            rx_data_out,
  output logic            rx_data_oe,
  output logic            shared_detect_output,
  output logic            shared_detect_oe,
  output msc_ana_t        ana,
  output msc_ctl_t        active_ctl
);

  // ---------------- link side, clocked by sck ----------------
  typedef struct packed {
    logic [`MSC_CTL_W-1:0] shift;
    logic [1:0]            edge_gray;
  } msc_lnk_st_t;

  msc_lnk_st_t lnk_r;
  msc_lnk_st_t lnk_nxt;

  function automatic logic [1:0] msc_gray2bin(input logic [1:0] g);
    return {g[1], g[1] ^ g[0]};
  endfunction

  function automatic logic [1:0] msc_bin2gray(input logic [1:0] b);
    return {b[1], b[1] ^ b[0]};
  endfunction

  // rw_dir only changes while sck is low, so it is steady at every sck edge
  always_comb begin
    lnk_nxt = lnk_r;
    if (!rw_dir) begin
      lnk_nxt.shift = {lnk_r.shift[`MSC_CTL_W-2:0], data_in};
    end else begin
      // read clocks are counted in gray so the clk side can sample safely
      lnk_nxt.edge_gray = msc_bin2gray(2'(msc_gray2bin(lnk_r.edge_gray) + 2'h1));
    end
  end

  // sck may stand still, so the link side takes reset without waiting for it
  always_ff @(posedge sck or posedge reset) begin
    if (reset) begin
      lnk_r <= '{shift: `MSC_CTL_RESET, edge_gray: 2'h0};
    end else begin
      lnk_r <= lnk_nxt;
    end
  end

  // ---------------- control side, clocked by clk ----------------
  typedef struct packed {
    logic                  en_s1;
    logic                  en_s2;
    logic                  en_s3;
    logic                  rw_s1;
    logic                  rw_s2;
    logic [`MSC_CTL_W-1:0] word_s1;
    logic [`MSC_CTL_W-1:0] word_s2;
    logic [1:0]            gray_s1;
    logic [1:0]            gray_s2;
    logic [1:0]            gray_seen;
    msc_ctl_t              ctl;
    logic [3:0]            status;
    logic [1:0]            rd_idx;
    logic                  data_out;
    logic                  rxd;
    logic                  rxd_oe;
    logic                  det;
    logic                  det_oe;
    msc_ana_t              ana;
  } msc_st_t;

  msc_st_t   st_r;
  msc_st_t   st_nxt;
  msc_mode_t mode_nxt;
  logic      load_ev;
  logic      latch_open;

  function automatic msc_mode_t msc_decode(input logic [3:0] code);
    msc_mode_t m;
    m = MSC_M_RSVD;
    case (code)
      `MSC_MODE_FSK:       m = MSC_M_FSK;
      `MSC_MODE_FSK_LOOP:  m = MSC_M_FSK_LOOP;
      `MSC_MODE_CALL_PROGRESS_DETECT:      m = MSC_M_CALL_PROGRESS_DETECT;
      `MSC_MODE_ANSWER:    m = MSC_M_ANSWER;
      `MSC_MODE_TONE_TX:   m = MSC_M_TONE_TX;
      `MSC_MODE_SINGLE:    m = MSC_M_SINGLE;
      `MSC_MODE_PD1:       m = MSC_M_PD1;
      `MSC_MODE_PD2:       m = MSC_M_PD2;
      `MSC_MODE_TONE_RX:   m = MSC_M_TONE_RX;
      `MSC_MODE_TONE_LOOP: m = MSC_M_TONE_LOOP;
      default:             m = MSC_M_RSVD;
    endcase
    return m;
  endfunction

  assign load_ev    = st_r.rw_s2 && st_r.en_s2 && !st_r.en_s3;
  assign latch_open = !st_r.rw_s2 && st_r.en_s2;

  always_comb begin
    st_nxt         = st_r;
    st_nxt.en_s1   = latch_en;
    st_nxt.en_s2   = st_r.en_s1;
    st_nxt.en_s3   = st_r.en_s2;
    st_nxt.rw_s1   = rw_dir;
    st_nxt.rw_s2   = st_r.rw_s1;
    // word is still while sck is parked, so it settles before en_s2 rises
    st_nxt.word_s1 = lnk_r.shift;
    st_nxt.word_s2 = st_r.word_s1;
    st_nxt.gray_s1 = lnk_r.edge_gray;
    st_nxt.gray_s2 = st_r.gray_s1;

    if (latch_open) begin
      st_nxt.ctl = msc_ctl_t'(st_r.word_s2);
    end

    if (load_ev) begin
      st_nxt.status    = rx_tone_code;
      st_nxt.rd_idx    = 2'h0;
      st_nxt.gray_seen = st_r.gray_s2;
    end else if (st_r.rw_s2) begin
      // several sck rises between samples are absorbed by the difference
      st_nxt.rd_idx    = 2'(st_r.rd_idx + msc_gray2bin(st_r.gray_s2)
                         - msc_gray2bin(st_r.gray_seen));
      st_nxt.gray_seen = st_r.gray_s2;
    end else begin
      // leaving read direction drops the position
      st_nxt.rd_idx    = 2'h0;
      st_nxt.gray_seen = st_r.gray_s2;
    end
    st_nxt.data_out = st_nxt.status[st_nxt.rd_idx];

    mode_nxt = msc_decode(st_nxt.ctl.mode);

    // defaults are the power-down 1 picture, with the oscillator left running
    st_nxt.rxd    = 1'b1;
    st_nxt.rxd_oe = 1'b0;
    st_nxt.det    = 1'b1;
    st_nxt.det_oe = 1'b0;
    st_nxt.ana    = '0;
    st_nxt.ana.osc_enable       = 1'b1;
    st_nxt.ana.tone_code        = st_nxt.ctl.tone;
    st_nxt.ana.tx_mute          = st_nxt.ctl.tx_mute;
    st_nxt.ana.line_band_select = st_nxt.ctl.line_band_select;
    st_nxt.ana.detect_time      = {st_nxt.ctl.detect_time_hi, st_nxt.ctl.detect_time_lo};

    unique case (mode_nxt)
      MSC_M_FSK, MSC_M_FSK_LOOP: begin
        st_nxt.ana.tx_enable    = 1'b1;
        st_nxt.ana.rx_enable    = 1'b1;
        st_nxt.ana.fsk_loopback = (mode_nxt == MSC_M_FSK_LOOP);
        st_nxt.det              = fsk_carrier_det_n;
        // no carrier means noise, so received data is held at mark
        st_nxt.rxd              = fsk_rx_data | fsk_carrier_det_n;
      end
      MSC_M_CALL_PROGRESS_DETECT: begin
        st_nxt.ana.rx_enable        = 1'b1;
        st_nxt.ana.call_progress_en = 1'b1;
        st_nxt.det                  = call_progress_detect_n;
      end
      MSC_M_ANSWER: begin
        st_nxt.ana.tx_enable      = 1'b1;
        st_nxt.ana.answer_tone_en = 1'b1;
      end
      MSC_M_TONE_TX: begin
        st_nxt.ana.tx_enable    = 1'b1;
        st_nxt.ana.dual_tone_en = 1'b1;
      end
      MSC_M_SINGLE: begin
        st_nxt.ana.tx_enable              = 1'b1;
        st_nxt.ana.single_tone_en         = 1'b1;
        st_nxt.ana.single_tone_high_group = st_nxt.ctl.tone[3];
      end
      MSC_M_TONE_RX: begin
        st_nxt.ana.rx_enable = 1'b1;
        st_nxt.det           = tone_valid_n;
      end
      MSC_M_TONE_LOOP: begin
        st_nxt.ana.tx_enable     = 1'b1;
        st_nxt.ana.rx_enable     = 1'b1;
        st_nxt.ana.dual_tone_en  = 1'b1;
        st_nxt.ana.tone_loopback = 1'b1;
        st_nxt.det               = tone_valid_n;
      end
      MSC_M_PD2: begin
        st_nxt.ana.osc_enable = 1'b0;
      end
      MSC_M_PD1, MSC_M_RSVD: begin
        // reserved codes are parked like power-down 1, the safest picture
        st_nxt.ana.osc_enable = 1'b1;
      end
    endcase

    if (mode_nxt != MSC_M_PD1 && mode_nxt != MSC_M_PD2 && mode_nxt != MSC_M_RSVD) begin
      st_nxt.ana.core_enable = 1'b1;
      st_nxt.ana.line_out_oe = 1'b1;
      st_nxt.rxd_oe          = 1'b1;
      st_nxt.det_oe          = 1'b1;
    end

    if (st_nxt.ana.tx_enable) begin
      st_nxt.ana.tx_atten_db = st_nxt.ctl.atten_gain;
    end
    if (mode_nxt == MSC_M_TONE_RX) begin
      if (st_nxt.ctl.atten_gain <= `MSC_AGC_MAX) begin
        st_nxt.ana.agc_gain_step = st_nxt.ctl.atten_gain;
      end
      st_nxt.ana.agc_clamp     = (st_nxt.ctl.atten_gain == `MSC_AGC_CLAMP);
      st_nxt.ana.agc_auto      = (st_nxt.ctl.atten_gain == `MSC_AGC_AUTO);
      st_nxt.ana.agc_undefined = (st_nxt.ctl.atten_gain > `MSC_AGC_AUTO);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r     <= '0;
      st_r.ctl <= msc_ctl_t'(`MSC_CTL_RESET);
      st_r.det <= 1'b1;
      st_r.rxd <= 1'b1;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign data_out             = st_r.data_out;
  assign data_oe              = st_r.rw_s2;
  assign rx_data_out          = st_r.rxd;
  assign rx_data_oe           = st_r.rxd_oe;
  assign shared_detect_output = st_r.det;
  assign shared_detect_oe     = st_r.det_oe;
  assign ana                  = st_r.ana;
  assign active_ctl           = st_r.ctl;

  // ---------------- checks ----------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  logic [3:0] m_r;
  assign m_r = st_r.ctl.mode;

  property p_reset_pd2;
    $past(reset) |-> (m_r == `MSC_MODE_PD2) && !ana.osc_enable && !rx_data_oe;
  endproperty
  a_reset_pd2: assert property (p_reset_pd2) else $error("reset did not enter pd2");

  property p_latch;
    latch_open && ce |=> st_r.ctl == $past(st_r.word_s2);
  endproperty
  a_latch: assert property (p_latch) else $error("open latch did not pass word");

  property p_isolate;
    !latch_open |=> $stable(st_r.ctl);
  endproperty
  a_isolate: assert property (p_isolate) else $error("closed latch changed mode");

  property p_load;
    load_ev && ce |=> data_out == $past(rx_tone_code[0]) && data_oe;
  endproperty
  a_load: assert property (p_load) else $error("status load not shown");

  property p_rotate;
    st_r.rw_s2 && !load_ev && ce && st_r.gray_s2 != st_r.gray_seen
      && msc_gray2bin(st_r.gray_s2) == 2'(msc_gray2bin(st_r.gray_seen) + 2'h1)
      |=> st_r.rd_idx == 2'($past(st_r.rd_idx) + 2'h1);
  endproperty
  a_rotate: assert property (p_rotate) else $error("status did not advance");

  property p_pd_tristate;
    (m_r == `MSC_MODE_PD1 || m_r == `MSC_MODE_PD2)
      |-> !rx_data_oe && !shared_detect_oe && !ana.line_out_oe && !ana.core_enable;
  endproperty
  a_pd_tristate: assert property (p_pd_tristate) else $error("pd output driven");

  property p_osc;
    m_r == `MSC_MODE_PD2 |-> !ana.osc_enable ##1 (m_r != `MSC_MODE_PD1 || ana.osc_enable);
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator state wrong");

  property p_rxd_high;
    (m_r inside {`MSC_MODE_CALL_PROGRESS_DETECT, `MSC_MODE_ANSWER, `MSC_MODE_TONE_TX,
                 `MSC_MODE_SINGLE, `MSC_MODE_TONE_RX}) |-> rx_data_out && rx_data_oe;
  endproperty
  a_rxd_high: assert property (p_rxd_high) else $error("rx data not forced high");

  property p_det_high;
    (m_r inside {`MSC_MODE_ANSWER, `MSC_MODE_TONE_TX, `MSC_MODE_SINGLE})
      |-> shared_detect_output && !ana.rx_enable;
  endproperty
  a_det_high: assert property (p_det_high) else $error("detect not high");

  property p_fsk_det;
    m_r == `MSC_MODE_FSK && $past(ce) && $past(m_r) == `MSC_MODE_FSK
      |-> shared_detect_output == $past(fsk_carrier_det_n);
  endproperty
  a_fsk_det: assert property (p_fsk_det) else $error("carrier detect wrong");

  property p_cpt_det;
    m_r == `MSC_MODE_CALL_PROGRESS_DETECT && $past(ce) && $past(m_r) == `MSC_MODE_CALL_PROGRESS_DETECT
      |-> shared_detect_output == $past(call_progress_detect_n) && ana.call_progress_en;
  endproperty
  a_cpt_det: assert property (p_cpt_det) else $error("call progress detect wrong");

  property p_tone_valid;
    (m_r == `MSC_MODE_TONE_RX || m_r == `MSC_MODE_TONE_LOOP) && $past(ce)
      && $past(m_r) == m_r
      |-> shared_detect_output == $past(tone_valid_n)
          && ana.tx_enable == (m_r == `MSC_MODE_TONE_LOOP);
  endproperty
  a_tone_valid: assert property (p_tone_valid) else $error("tone valid wrong");

  property p_atten;
    ana.tx_enable |-> ana.tx_atten_db == st_r.ctl.atten_gain;
  endproperty
  a_atten: assert property (p_atten) else $error("attenuation mismatch");

  property p_agc_auto;
    m_r == `MSC_MODE_TONE_RX |-> ana.agc_auto == (st_r.ctl.atten_gain == `MSC_AGC_AUTO)
      && ana.agc_clamp == (st_r.ctl.atten_gain == `MSC_AGC_CLAMP);
  endproperty
  a_agc_auto: assert property (p_agc_auto) else $error("agc code wrong");

endmodule // msc_serial_mode_control

`default_nettype wire

// *** include/msc_map.svh ***
// Purpose: constants for the modem serial mode control block
// Assumes: included by msc_pkg and the core
// Notes:   control word is shifted in msb first
`ifndef MSC_MAP_SVH
`define MSC_MAP_SVH

`define MSC_CTL_W        16
`define MSC_STATUS_W     4
`define MSC_MODE_HI      15
`define MSC_MODE_LO      12
`define MSC_ATTEN_HI     11
`define MSC_ATTEN_LO     8
`define MSC_TONE_HI      7
`define MSC_TONE_LO      4
`define MSC_MUTE_BIT     3
`define MSC_BAND_BIT     2
`define MSC_DT_HI        1
`define MSC_DT_LO        0

`define MSC_MODE_FSK       4'h0
`define MSC_MODE_FSK_LOOP  4'h1
`define MSC_MODE_CALL_PROGRESS_DETECT      4'h2
`define MSC_MODE_ANSWER    4'h3
`define MSC_MODE_TONE_TX   4'h4
`define MSC_MODE_SINGLE    4'h5
`define MSC_MODE_PD1       4'h6
`define MSC_MODE_PD2       4'h7
`define MSC_MODE_TONE_RX   4'h8
`define MSC_MODE_TONE_LOOP 4'h9

// power-on state is power-down 2, all other fields zero
`define MSC_CTL_RESET    16'h7000
`define MSC_AGC_MAX      4'ha
`define MSC_AGC_CLAMP    4'hb
`define MSC_AGC_AUTO     4'hc

`endif

// *** include/msc_pkg.sv ***
// Purpose: types of the modem serial mode control block
// Assumes: msc_map.svh on the include path
// Notes:   constants live in the header, types here
`include "msc_map.svh"

package msc_pkg;

  typedef enum logic [3:0] {
    MSC_M_FSK,
    MSC_M_FSK_LOOP,
    MSC_M_CALL_PROGRESS_DETECT,
    MSC_M_ANSWER,
    MSC_M_TONE_TX,
    MSC_M_SINGLE,
    MSC_M_PD1,
    MSC_M_PD2,
    MSC_M_TONE_RX,
    MSC_M_TONE_LOOP,
    MSC_M_RSVD
  } msc_mode_t;

  typedef struct packed {
    logic [3:0] mode;
    logic [3:0] atten_gain;
    logic [3:0] tone;
    logic       tx_mute;
    logic       line_band_select;
    logic       detect_time_hi;
    logic       detect_time_lo;
  } msc_ctl_t;

  typedef struct packed {
    logic       osc_enable;
    logic       core_enable;
    logic       tx_enable;
    logic       rx_enable;
    logic       line_out_oe;
    logic       fsk_loopback;
    logic       tone_loopback;
    logic       call_progress_en;
    logic       answer_tone_en;
    logic       dual_tone_en;
    logic       single_tone_en;
    logic       single_tone_high_group;
    logic [3:0] tone_code;
    logic [3:0] tx_atten_db;
    logic [3:0] agc_gain_step;
    logic       agc_clamp;
    logic       agc_auto;
    logic       agc_undefined;
    logic       tx_mute;
    logic       line_band_select;
    logic [1:0] detect_time;
  } msc_ana_t;

endpackage

// *** tb/modem_serial_mode_control_tb.sv ***
// Purpose: self-checking bench of the serial mode control block
// Assumes: host model drives the serial pins, detect inputs driven here
// Notes:   fsk receive data held low so forced-high rx data is visible
`timescale 1ns/1ps
`default_nettype none

module modem_serial_mode_control_tb
  import msc_pkg::*;
();
  logic       clk;
  logic       reset;
  logic       ce;
  logic       sck;
  logic       latch_en;
  logic       rw_dir;
  logic       host_d;
  logic       data_w;
  logic       data_out;
  logic       data_oe;
  logic       fsk_rx_data;
  logic [2:0] det_n;
  logic [3:0] rx_tone_code;
  logic       rx_data_out;
  logic       rx_data_oe;
  logic       sd_out;
  logic       sd_oe;
  msc_ana_t   ana;
  msc_ctl_t   active_ctl;
  int         fail_count;
  int         comparisons;

  // data pin level from both parties' drive
  assign data_w = data_oe ? data_out : host_d;

  msc_host_model u_msc_host_model (.clk(clk), .sck(sck), .latch_en(latch_en),
    .rw_dir(rw_dir), .data_d(host_d));

  msc_serial_mode_control u_msc_serial_mode_control (.clk(clk), .reset(reset), .ce(ce),
    .sck(sck), .latch_en(latch_en), .rw_dir(rw_dir), .data_in(data_w), .data_out(data_out),
    .data_oe(data_oe), .fsk_rx_data(fsk_rx_data), .fsk_carrier_det_n(det_n[0]),
    .call_progress_detect_n(det_n[1]), .tone_valid_n(det_n[2]), .rx_tone_code(rx_tone_code),
    .rx_data_out(rx_data_out), .rx_data_oe(rx_data_oe), .shared_detect_output(sd_out),
    .shared_detect_oe(sd_oe), .ana(ana), .active_ctl(active_ctl));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic load(input logic [15:0] w);
    u_msc_host_model.write_word(w);
    u_msc_host_model.pulse_latch(1'b0);
    repeat (2) @(posedge clk);
    #1;
  endtask

  initial begin
    #200_000;
    fail_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    logic [3:0]  mode;
    logic [15:0] word;
    logic        pd;
    logic        dv;
    logic [3:0]  stat_exp;
    int          idx;
    reset        = 1'b1;
    ce           = 1'b1;
    fsk_rx_data  = 1'b0;
    det_n        = 3'h7;
    rx_tone_code = 4'h3;
    fail_count   = 0;
    comparisons  = 0;
    repeat (5) @(posedge clk);
    #1;
    reset = 1'b0;
    chk_vec(active_ctl, 16'h7000, "reset word");
    chk_bit(ana.osc_enable, 1'b0, "reset osc");
    chk_bit(rx_data_oe | sd_oe | data_oe, 1'b0, "reset oe");
    for (int m = 0; m < 10; m++) begin
      mode = 4'(m);
      word = {mode, mode ^ 4'h5, ~mode, 4'h9};
      pd = (m == 6) || (m == 7);
      load(word);
      chk_vec(active_ctl, word, "latched word");
      chk_bit(rx_data_oe, !pd, "rx oe");
      chk_bit(sd_oe, !pd, "detect oe");
      chk_bit(ana.osc_enable, m != 7, "osc");
      chk_bit(ana.line_out_oe, !pd, "line oe");
      chk_bit(ana.core_enable, !pd, "core on");
      chk_vec(16'({ana.tx_mute, ana.line_band_select, ana.detect_time}), 16'h0009, "low");
      chk_bit(ana.tx_enable, m inside {0, 1, 3, 4, 5, 9}, "tx on");
      chk_bit(ana.rx_enable, m inside {0, 1, 2, 8, 9}, "rx on");
      chk_vec(16'(ana.tx_atten_db), (m inside {0, 1, 3, 4, 5, 9}) ? 16'(mode ^ 4'h5) : 16'h0000,
        "atten");
      chk_bit(ana.fsk_loopback, m == 1, "fsk loop");
      chk_bit(ana.tone_loopback, m == 9, "tone loop");
      chk_bit(ana.call_progress_en, m == 2, "call_progress_detect");
      chk_bit(ana.answer_tone_en, m == 3, "answer");
      chk_bit(ana.dual_tone_en, m == 4 || m == 9, "dual tone");
      chk_bit(ana.single_tone_en, m == 5, "single tone");
      if (m inside {4, 5, 9}) begin
        chk_vec({12'h000, ana.tone_code}, {12'h000, ~mode}, "tone code");
      end
      if (m == 5) begin
        chk_bit(ana.single_tone_high_group, ~mode[3], "tone group");
      end
      idx = (m < 2) ? 0 : (m == 2) ? 1 : 2;
      for (int d = 0; d < 2; d++) begin
        dv = d[0];
        det_n = {3{~dv}};
        det_n[idx] = dv;
        repeat (4) @(posedge clk);
        #1;
        if (!pd) begin
          chk_bit(sd_out, (m inside {3, 4, 5}) ? 1'b1 : dv, "detect");
          chk_bit(rx_data_out, (m < 2) ? dv : 1'b1, "rx data");
        end
      end
    end
    // reserved code: only the latched word is relied on
    load(16'ha000);
    chk_vec(active_ctl, 16'ha000, "reserved latched");
    // latch pulse while frozen is never seen by the clk side
    ce = 1'b0;
    load(16'h0000);
    chk_vec(active_ctl, 16'ha000, "frozen by ce");
    ce = 1'b1;
    for (int c = 0; c < 16; c++) begin
      load({4'h8, 4'(c), 8'h00});
      chk_vec({12'h000, ana.agc_gain_step}, (c <= 10) ? 16'(c) : 16'h0000, "agc");
      chk_bit(ana.agc_clamp, c == 11, "clamp");
      chk_bit(ana.agc_auto, c == 12, "auto");
      chk_bit(ana.agc_undefined, c >= 13, "undef");
      chk_vec({12'h000, ana.tx_atten_db}, 16'h0000, "rx no atten");
    end
    load(16'h8c00);
    stat_exp     = 4'h3;
    rx_tone_code = stat_exp;
    u_msc_host_model.pulse_latch(1'b1);
    // later decoder changes must not reach a stream already loaded
    rx_tone_code = 4'hc;
    chk_bit(data_oe, 1'b1, "read oe");
    chk_bit(data_out, stat_exp[0], "first bit");
    for (int k = 1; k < 6; k++) begin
      u_msc_host_model.read_clock();
      chk_bit(data_out, stat_exp[k % 4], "stream bit");
    end
    u_msc_host_model.pulse_latch(1'b0);
    repeat (2) @(posedge clk);
    #1;
    chk_vec(active_ctl, 16'h8c00, "read clocks no shift");
    finish_test();
  end
endmodule // modem_serial_mode_control_tb

`default_nettype wire

// *** tb/msc_host_model.sv ***
// Purpose: host processor model driving the serial control pins
// Assumes: clk is the system clock; sck runs at 15 ns only inside frames
// Notes:   released data line alternates so a stale bit never looks valid
`timescale 1ns/1ps
`default_nettype none

module msc_host_model (
  input  wire logic clk,
  output logic      sck,
  output logic      latch_en,
  output logic      rw_dir,
  output logic      data_d
);
  logic busy;

  initial begin
    sck      = 1'b0;
    latch_en = 1'b0;
    rw_dir   = 1'b0;
    data_d   = 1'b0;
    busy     = 1'b0;
  end

  always @(posedge clk) begin
    if (!busy) begin
      data_d <= ~data_d;
    end
  end

  // msb first; trigger stays low for the whole shift
  task automatic write_word(input logic [15:0] w);
    @(posedge clk);
    #1;
    rw_dir = 1'b0;
    // wait for the device to release the data line
    repeat (3) @(posedge clk);
    #1;
    busy = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      data_d = w[i];
      #3.75 sck = 1'b1;
      #7.5 sck = 1'b0;
      #3.75;
    end
    busy = 1'b0;
  endtask

  // direction changes only with sck and trigger low; sck low while trigger high
  task automatic pulse_latch(input logic dir);
    @(posedge clk);
    #1;
    rw_dir = dir;
    repeat (2) @(posedge clk);
    #1;
    latch_en = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    latch_en = 1'b0;
  endtask

  // reads need wide sck spacing for the clk side to follow
  task automatic read_clock();
    @(posedge clk);
    #1;
    sck = 1'b1;
    #7.5 sck = 1'b0;
    repeat (6) @(posedge clk);
    // let the edge settle before anyone samples data_out
    #1;
  endtask
endmodule // msc_host_model

`default_nettype wire
